// >>> rtl/pit_pkg.sv
/*
  shared constants for both ends of the parallel interface/timer host bus port.
  assumes one clock, mclk, at 250 mhz; one mclk period stands for one device clock.
*/
// Functional notes
// (R1) sample chip select and strobe each clock
// (R2) dma request asserted three clocks after select
// (R3) dma request held three clock periods
// (R4) port irq asserted three clocks after strobe
// (R5) irq released three clocks after clearing access
// (R6) internal work done three clocks after acknowledge
// (R7) new select waits until internal work done
// (R8) acknowledge may come one clock late
// (R9) host holds select until acknowledge seen
// (R10) timer input at most clock rate, prescaled
// (R11) timer input at most eighth rate, bypassed
// (R12) run/halt low held at least one clock
// (R13) timer input period exceeds clock period
// (R14) acknowledge and data released when cycle ends
package pit_pkg;
  localparam int unsigned  MCLK_HZ          = 250_000_000;
  localparam int unsigned  DATA_W           = 8;
  localparam int unsigned  RS_W             = 5;
  // delays in device clock periods, one mclk each
  localparam int unsigned  DMA_DELAY_CYC    = 3;
  localparam int unsigned  DMA_HOLD_CYC     = 3;
  localparam int unsigned  IRQ_DELAY_CYC    = 3;
  localparam int unsigned  BUSY_CYC         = 3;
  localparam logic [1:0]   BUSY_LOAD        = 2'h3;
  localparam logic [RS_W-1:0] IRQ_CLEAR_RS  = 5'h0d;
  // timer input hold per level: period 2 prescaled, 8 bypassed
  localparam logic [2:0]   TIN_HOLD_PRE     = 3'h1;
  localparam logic [2:0]   TIN_HOLD_BYP     = 3'h4;
  localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_load = 4'b0010,
    st_ack  = 4'b0100,
    st_neg  = 4'b1000
  } dev_state_t;

  typedef enum logic [3:0] {
    hs_idle = 4'b0001,
    hs_wait = 4'b0010,
    hs_end  = 4'b0100,
    hs_rel  = 4'b1000
  } host_state_t;
endpackage : pit_pkg

// >>> rtl/pit_bus_if.sv
/*
  bus wires between the host end and the device end.
  assumes both ends run on the same mclk; open-drain and three-state pins are
  resolved here from the drivers' enables, undriven lines read high.
*/
interface pit_bus_if;
  import pit_pkg::*;
  logic              cs_n;
  logic              rw_n;
  logic [RS_W-1:0]   register_select;
  logic              port_vector_ack_n;
  logic              timer_vector_ack_n;
  logic [DATA_W-1:0] data_host;
  logic [DATA_W-1:0] data_dev;
  logic              data_dev_oe;
  logic              ack_out;
  logic              ack_oe;
  logic              transfer_ack_n;
  logic              dma_request_n;
  logic              irq_oe;
  logic              port_irq_n;
  logic              handshake_in_strobe;
  logic              timer_input;
  logic [DATA_W-1:0] data_bus;

  assign transfer_ack_n = ack_oe ? ack_out : 1'b1;
  assign port_irq_n     = irq_oe ? 1'b0 : 1'b1;
  assign data_bus       = data_dev_oe ? data_dev : data_host;

  modport device (
    input  cs_n, rw_n, register_select, port_vector_ack_n, timer_vector_ack_n,
    input  data_host, handshake_in_strobe, timer_input,
    output data_dev, data_dev_oe, ack_out, ack_oe, dma_request_n, irq_oe
  );
  modport host (
    output cs_n, rw_n, register_select, port_vector_ack_n, timer_vector_ack_n,
    output data_host, timer_input,
    input  data_bus, transfer_ack_n, dma_request_n, port_irq_n
  );
endinterface : pit_bus_if

// >>> rtl/pit_device_end.sv
/*
  device end: bus cycle sequencing, dma request and port interrupt timing,
  timer input sampling.
  assumes bus inputs are synchronous to mclk; the strobe source drives
  handshake_in_strobe inside the interface from the bench.
*/
module pit_device_end
  import pit_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  pit_bus_if.device              bus,
  input  wire logic              dma_enable,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic [DATA_W-1:0] port_vector,
  input  wire logic [DATA_W-1:0] timer_vector,
  output logic                   acc_start_ff,
  output logic [RS_W-1:0]        acc_addr_ff,
  output logic                   wr_pulse_ff,
  output logic [DATA_W-1:0]      wr_data_ff,
  output logic                   busy_ff,
  output logic                   timer_tick_ff,
  output logic                   timer_halt_ff
);
  dev_state_t         state_ff;
  dev_state_t         nxt_state;
  logic [1:0]         busy_cnt_ff;
  logic [1:0]         kind_ff;
  logic               rw_n_ff;
  logic               strobe_ff;
  logic               tin_ff;
  logic [1:0]         dma_hold_ff;
  logic [DATA_W-1:0]  data_dev_ff;
  logic               data_oe_ff;
  logic               ack_out_ff;
  logic               ack_oe_ff;
  logic               dma_n_ff;
  logic               irq_oe_ff;
  logic               active;
  logic               start;
  logic               strobe_event;
  logic               clear_event;
  logic               dma_event;
  logic [2:0]         ev;
  logic [2:0]         ev_due;

  assign bus.data_dev      = data_dev_ff;
  assign bus.data_dev_oe   = data_oe_ff;
  assign bus.ack_out       = ack_out_ff;
  assign bus.ack_oe        = ack_oe_ff;
  assign bus.dma_request_n = dma_n_ff;
  assign bus.irq_oe        = irq_oe_ff;

  // a cycle is open while select or either vector acknowledge is low
  assign active = !bus.cs_n || !bus.port_vector_ack_n || !bus.timer_vector_ack_n;
  // one clock between sampling and acknowledge leaves room for the read path
  assign start  = (state_ff == st_idle) && active && (busy_cnt_ff == 2'h0); // (R1) (R7)
  assign dma_event   = start && !bus.cs_n && dma_enable;
  assign clear_event = start && !bus.cs_n && !bus.rw_n
                       && (bus.register_select == IRQ_CLEAR_RS);
  assign strobe_event = strobe_ff && !bus.handshake_in_strobe; // (R1)
  assign ev = {clear_event, strobe_event, dma_event};

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_idle: begin
        if (start) begin
          nxt_state = st_load;
        end
      end
      st_load: begin
        nxt_state = st_ack;
      end
      st_ack: begin
        if (!active) begin
          nxt_state = st_neg; // (R14)
        end
      end
      st_neg: begin
        nxt_state = st_idle;
      end
      default: begin
        nxt_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // three-stage delay line per event: dma, strobe, clearing access
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_delay
      logic [2:0] line_ff;
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          line_ff <= 3'h0;
        end else begin
          line_ff <= {line_ff[1:0], ev[gi]}; // (R2) (R4) (R5)
        end
      end
      assign ev_due[gi] = line_ff[DMA_DELAY_CYC-1];
    end
  endgenerate

  // access capture, data and acknowledge drive
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc_start_ff <= 1'b0;
      acc_addr_ff  <= '0;
      kind_ff      <= 2'h0;
      rw_n_ff      <= 1'b1;
      wr_pulse_ff  <= 1'b0;
      wr_data_ff   <= DATA_RESET;
      data_dev_ff  <= DATA_RESET;
      data_oe_ff   <= 1'b0;
      ack_out_ff   <= 1'b1;
      ack_oe_ff    <= 1'b0;
    end else begin
      acc_start_ff <= start;
      wr_pulse_ff  <= 1'b0;
      if (start) begin
        acc_addr_ff <= bus.register_select;
        kind_ff     <= !bus.cs_n ? 2'h0 : (!bus.port_vector_ack_n ? 2'h1 : 2'h2);
        rw_n_ff     <= bus.rw_n;
        if (!bus.cs_n && !bus.rw_n) begin
          wr_pulse_ff <= 1'b1;
          wr_data_ff  <= bus.data_host;
        end
      end
      if (state_ff == st_load) begin
        ack_out_ff <= 1'b0; // (R8)
        ack_oe_ff  <= 1'b1;
        if (kind_ff != 2'h0 || rw_n_ff) begin
          data_oe_ff  <= 1'b1;
          data_dev_ff <= (kind_ff == 2'h1) ? port_vector :
                         (kind_ff == 2'h2) ? timer_vector : rd_data;
        end
      end
      if (state_ff == st_ack && !active) begin
        ack_out_ff <= 1'b1; // (R14)
        data_oe_ff <= 1'b0; // (R14)
      end
      if (state_ff == st_neg) begin
        ack_oe_ff <= 1'b0; // (R14)
      end
    end
  end

  // internal work of a cycle ends three clocks after its acknowledge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_cnt_ff <= 2'h0;
      busy_ff     <= 1'b0;
    end else begin
      if (state_ff == st_load) begin
        busy_cnt_ff <= BUSY_LOAD; // (R6)
        busy_ff     <= 1'b1;
      end else if (busy_cnt_ff != 2'h0) begin
        busy_cnt_ff <= busy_cnt_ff - 2'h1; // (R6)
        busy_ff     <= (busy_cnt_ff != 2'h1);
      end
    end
  end

  // dma request: low from its due clock for exactly three clocks
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dma_n_ff    <= 1'b1;
      dma_hold_ff <= 2'h0;
    end else begin
      if (ev_due[0]) begin
        dma_n_ff    <= 1'b0; // (R2)
        dma_hold_ff <= 2'(DMA_HOLD_CYC - 1);
      end else if (dma_hold_ff != 2'h0) begin
        dma_hold_ff <= dma_hold_ff - 2'h1; // (R3)
      end else begin
        dma_n_ff <= 1'b1; // (R3)
      end
    end
  end

  // port interrupt: a strobe due in the same clock as a release wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_oe_ff <= 1'b0;
    end else begin
      if (ev_due[1]) begin
        irq_oe_ff <= 1'b1; // (R4)
      end else if (ev_due[2]) begin
        irq_oe_ff <= 1'b0; // (R5)
      end
    end
  end

  // timer input: edge per sampled rise, halt while low; a faster input is lost
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strobe_ff     <= 1'b1;
      // idle level of the pin: a low here would fake a tick right after reset
      tin_ff        <= 1'b1;
      timer_tick_ff <= 1'b0;
      timer_halt_ff <= 1'b0;
    end else begin
      strobe_ff     <= bus.handshake_in_strobe;
      tin_ff        <= bus.timer_input;
      timer_tick_ff <= bus.timer_input && !tin_ff; // (R13)
      timer_halt_ff <= !bus.timer_input; // (R12)
    end
  end
endmodule : pit_device_end

// >>> rtl/pit_host_end.sv
/*
  host end: runs one bus cycle per request and paces the timer input.
  assumes the device end shares mclk and answers with an acknowledge.
*/
module pit_host_end
  import pit_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  pit_bus_if.host                bus,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [1:0]        req_kind,
  input  wire logic [RS_W-1:0]   req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready_ff,
  output logic                   rsp_valid_ff,
  output logic [DATA_W-1:0]      rsp_rdata_ff,
  input  wire logic              prescaler_used,
  input  wire logic              timer_level
);
  host_state_t        state_ff;
  logic               cs_n_ff;
  logic               rw_n_ff;
  logic [RS_W-1:0]    rs_ff;
  logic               pvack_n_ff;
  logic               tvack_n_ff;
  logic [DATA_W-1:0]  wdata_ff;
  logic               tin_ff;
  logic [2:0]         tin_cnt_ff;

  assign bus.cs_n               = cs_n_ff;
  assign bus.rw_n               = rw_n_ff;
  assign bus.register_select    = rs_ff;
  assign bus.port_vector_ack_n  = pvack_n_ff;
  assign bus.timer_vector_ack_n = tvack_n_ff;
  assign bus.data_host          = wdata_ff;
  assign bus.timer_input        = tin_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff     <= hs_idle;
      cs_n_ff      <= 1'b1;
      rw_n_ff      <= 1'b1;
      rs_ff        <= '0;
      pvack_n_ff   <= 1'b1;
      tvack_n_ff   <= 1'b1;
      wdata_ff     <= DATA_RESET;
      req_ready_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= DATA_RESET;
    end else begin
      rsp_valid_ff <= 1'b0;
      case (state_ff)
        hs_idle: begin
          req_ready_ff <= 1'b1;
          if (req_valid && req_ready_ff) begin
            req_ready_ff <= 1'b0;
            rw_n_ff      <= !req_write || (req_kind != 2'h0);
            rs_ff        <= req_addr;
            wdata_ff     <= req_wdata;
            cs_n_ff      <= (req_kind != 2'h0);
            pvack_n_ff   <= (req_kind != 2'h1);
            tvack_n_ff   <= (req_kind != 2'h2);
            state_ff     <= hs_wait;
          end
        end
        hs_wait: begin
          // no bound on the wait: a late or postponed acknowledge is legal
          if (!bus.transfer_ack_n) begin // (R8) (R9)
            rsp_rdata_ff <= bus.data_bus;
            cs_n_ff      <= 1'b1;
            pvack_n_ff   <= 1'b1;
            tvack_n_ff   <= 1'b1;
            state_ff     <= hs_end;
          end
        end
        hs_end: begin
          if (bus.transfer_ack_n) begin
            state_ff <= hs_rel;
          end
        end
        hs_rel: begin
          rsp_valid_ff <= 1'b1;
          rw_n_ff      <= 1'b1;
          state_ff     <= hs_idle;
        end
        default: begin
          state_ff <= hs_idle;
        end
      endcase
    end
  end

  // each timer level stands its minimum time, bounding the input rate
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tin_ff     <= 1'b1;
      tin_cnt_ff <= 3'h0;
    end else begin
      if (tin_cnt_ff != 3'h0) begin
        tin_cnt_ff <= tin_cnt_ff - 3'h1;
      end else if (timer_level != tin_ff) begin
        tin_ff     <= timer_level; // (R12)
        tin_cnt_ff <= (prescaler_used ? TIN_HOLD_PRE : TIN_HOLD_BYP) - 3'h1; // (R10) (R11) (R13)
      end
    end
  end
endmodule : pit_host_end

// >>> tb/pit_bus_assertions.sv
/* checker for the wires between the host end and the device end.
   assumes one clock, mclk, and the low-active reset resetn. */
module pit_bus_assertions
  import pit_pkg::*;
(
  input wire logic            mclk,
  input wire logic            resetn,
  input wire logic            cs_n,
  input wire logic            rw_n,
  input wire logic [RS_W-1:0] register_select,
  input wire logic            port_vector_ack_n,
  input wire logic            timer_vector_ack_n,
  input wire logic            data_dev_oe,
  input wire logic            ack_out,
  input wire logic            ack_oe,
  input wire logic            transfer_ack_n,
  input wire logic            dma_request_n,
  input wire logic            irq_oe,
  input wire logic            handshake_in_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic sel;
  logic clr_req;
  assign sel = !cs_n || !port_vector_ack_n || !timer_vector_ack_n;
  assign clr_req = !cs_n && !rw_n && register_select == IRQ_CLEAR_RS;
  sequence ack_end_s;
    ack_out && !data_dev_oe ##1 !ack_oe;
  endsequence
  sequence strobe_edge_s;
    handshake_in_strobe ##1 !handshake_in_strobe;
  endsequence
  a_ack_after_sel: assert property ($rose(ack_oe) |-> $past(sel, 2) && !ack_out)
    else $error("acknowledge without a select");
  a_ack_held: assert property (ack_oe && !ack_out && sel |=> ack_oe && !ack_out)
    else $error("acknowledge dropped during cycle");
  a_ack_release: assert property (ack_oe && !ack_out && !sel |=> ack_end_s)
    else $error("acknowledge not released");
  a_host_holds: assert property (!cs_n && transfer_ack_n |=> !cs_n)
    else $error("select dropped before acknowledge");
  // busy window keeps a fresh acknowledge away
  a_busy_gap: assert property ($rose(ack_oe) |=> (!$rose(ack_oe)) [*4])
    else $error("new cycle while busy");
  a_dma_delay: assert property ($fell(dma_request_n) |-> $past(cs_n, 4) == 1'b0)
    else $error("dma request at wrong time");
  a_dma_width: assert property ($fell(dma_request_n) |->
    !dma_request_n [*3] ##1 dma_request_n)
    else $error("dma request width wrong");
  a_irq_set: assert property (strobe_edge_s |-> ##4 irq_oe)
    else $error("port irq late");
  a_irq_clear: assert property ($fell(irq_oe) |-> $past(clr_req, 4))
    else $error("port irq released without clear");
endmodule : pit_bus_assertions

// >>> tb/tb.sv
/* self-checking bench: host end and device end joined by the bus interface.
   assumes 250 mhz mclk; stimulus changes on falling edges. */
module tb
  import pit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, resetn, dma_enable, req_valid, req_write, prescaler_used, timer_level;
  logic [1:0]        req_kind;
  logic [RS_W-1:0]   req_addr;
  logic [DATA_W-1:0] req_wdata, rd_data, rsp_rdata_ff, wr_data_ff, acc_q, last_wr;
  logic acc_start_ff, wr_pulse_ff, busy_ff, timer_tick_ff, timer_halt_ff;
  logic req_ready_ff, rsp_valid_ff, dma_prev;
  logic [RS_W-1:0]   acc_addr_ff;
  int fails, checked, since, dma_low, dma_lat, ticks, busy_cyc;
  pit_bus_if bus ();
  pit_device_end i_pit_device_end (.mclk(mclk), .resetn(resetn), .bus(bus),
    .dma_enable(dma_enable), .rd_data(rd_data), .port_vector(8'ha5),
    .timer_vector(8'h3c), .acc_start_ff(acc_start_ff), .acc_addr_ff(acc_addr_ff),
    .wr_pulse_ff(wr_pulse_ff), .wr_data_ff(wr_data_ff), .busy_ff(busy_ff),
    .timer_tick_ff(timer_tick_ff), .timer_halt_ff(timer_halt_ff));
  pit_host_end i_pit_host_end (.mclk(mclk), .resetn(resetn), .bus(bus),
    .req_valid(req_valid), .req_write(req_write), .req_kind(req_kind),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready_ff(req_ready_ff),
    .rsp_valid_ff(rsp_valid_ff), .rsp_rdata_ff(rsp_rdata_ff),
    .prescaler_used(prescaler_used), .timer_level(timer_level));
  pit_bus_assertions i_pit_bus_assertions (.mclk(mclk), .resetn(resetn),
    .cs_n(bus.cs_n), .rw_n(bus.rw_n), .register_select(bus.register_select),
    .port_vector_ack_n(bus.port_vector_ack_n), .timer_vector_ack_n(bus.timer_vector_ack_n),
    .data_dev_oe(bus.data_dev_oe), .ack_out(bus.ack_out), .ack_oe(bus.ack_oe),
    .transfer_ack_n(bus.transfer_ack_n), .dma_request_n(bus.dma_request_n),
    .irq_oe(bus.irq_oe), .handshake_in_strobe(bus.handshake_in_strobe));

  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  // read data follows the latched address, half a clock before it is taken
  always @(negedge mclk) rd_data <= {3'h5, acc_addr_ff};
  always @(posedge mclk) begin
    since = acc_start_ff ? 0 : since + 1;
    if (bus.dma_request_n === 1'b0) dma_low++;
    if (busy_ff === 1'b1) busy_cyc++;
    if (bus.dma_request_n === 1'b0 && dma_prev) dma_lat = since;
    dma_prev = bus.dma_request_n;
    if (timer_tick_ff === 1'b1) ticks++;
    if (wr_pulse_ff === 1'b1) last_wr = wr_data_ff;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic access(input logic wr, input logic [1:0] kind, input logic [4:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    dma_low = 0;
    busy_cyc = 0;
    while (req_ready_ff !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    req_valid = 1;
    req_write = wr;
    req_kind = kind;
    req_addr = a;
    req_wdata = d;
    @(negedge mclk);
    req_valid = 0;
    n = 0;
    while (rsp_valid_ff !== 1'b1 && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    acc_q = rsp_rdata_ff;
    check(n < 50, 1);
    repeat (8) @(negedge mclk);
  endtask : access

  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  initial begin
    #120000;
    fails++;
    give_verdict;
  end

  initial begin
    {resetn, req_valid, req_write, req_kind, req_addr, req_wdata} = '0;
    {dma_enable, prescaler_used, dma_prev} = 3'b111;
    {timer_level, bus.handshake_in_strobe} = 2'b11;
    {since, dma_low, dma_lat, ticks, busy_cyc, last_wr} = '0;
    repeat (12) @(negedge mclk);
    resetn = 1;
    for (int a = 1; a < 5; a++) begin
      access(1, 0, a, 8'h30 + a);
      check(last_wr, 8'h30 + a);
      check(busy_cyc, BUSY_CYC);
      check(dma_lat, 3);
      check(dma_low, 3);
      access(0, 0, a, 0);
      check(acc_q, {3'h5, a[4:0]});
    end
    check(ticks, 0);
    dma_enable = 0;
    access(0, 0, 5'h07, 0);
    check(dma_low, 0);
    access(0, 1, 0, 0);
    check(acc_q, 8'ha5);
    access(0, 2, 0, 0);
    check(acc_q, 8'h3c);
    bus.handshake_in_strobe = 0;
    repeat (2) @(negedge mclk);
    bus.handshake_in_strobe = 1;
    repeat (6) @(negedge mclk);
    check(bus.port_irq_n, 0);
    access(0, 0, IRQ_CLEAR_RS, 0);
    check(bus.port_irq_n, 0);
    access(1, 0, IRQ_CLEAR_RS, 8'h11);
    check(bus.port_irq_n, 1);
    for (int p = 0; p < 2; p++) begin
      prescaler_used = p[0];
      ticks = 0;
      repeat (3) begin
        timer_level = 0;
        repeat (12) @(negedge mclk);
        check(timer_halt_ff, 1);
        timer_level = 1;
        repeat (12) @(negedge mclk);
        check(timer_halt_ff, 0);
      end
      check(ticks, 3);
    end
    give_verdict;
  end
endmodule : tb
